// ===== pbm_pkg.sv
// Function
// RULE_01 - Power-up in bypassed compatibility mode
// RULE_02 - Reserved access key unlocks blend mode
// RULE_03 - Compatibility components six bit, width select
// RULE_04 - Narrow writes stored left-justified, low zeros
// RULE_05 - Narrow reads right-justified, upper bits zero
// RULE_06 - Mode byte shifted on write, not read
// RULE_07 - Blend mode stores all eight bits unshifted
// RULE_08 - Host enables blend before loading wide colours
// RULE_09 - Left colour in second, right in first
// RULE_10 - Mix formula with rounding over thirty-one
// RULE_11 - Three matched channels per pixel
// RULE_12 - Two encodings; dynamic palette separate-pixel only
// RULE_13 - Load opcode rewrites palette mid-image
// RULE_14 - Replication compensation for doubled pixels
// RULE_15 - Gamma only while blend mode enabled
// RULE_16 - Single-pixel fields; second bank offset sixteen
// RULE_17 - Single-pixel mix weights table
// RULE_18 - Load opcode seven or 191
// RULE_19 - Mode state from mode byte, reset clears
// RULE_20 - Division truncates, eight-bit result
package pbm_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] A_WADDR  = 8'h00;
   localparam logic [7:0] A_DATA   = 8'h04;
   localparam logic [7:0] A_RADDR  = 8'h08;
   localparam logic [7:0] A_CTRL   = 8'h0c;
   localparam logic [7:0] A_STATUS = 8'h10;
   localparam logic [7:0] A_NONE   = 8'hff;
   localparam int         CTRL_WIDE8 = 0;
   localparam logic       WIDE8_RESET = 1'b0;

   // ****************************************
   // Key sequence and mode byte
   // ****************************************
   localparam logic [7:0] KEY0       = 8'ha5;
   localparam logic [7:0] KEY1       = 8'h5a;
   localparam logic [7:0] KEY2       = 8'hdf;
   localparam logic [7:0] MODE_ENTRY = 8'hdf;
   localparam int         MODE_BLEND = 2;
   localparam int         MODE_ENC   = 3;
   localparam int         MODE_DYN   = 5;
   localparam int         MODE_REPL  = 6;
   localparam logic [1:0] KEY_DONE   = 2'h3;

   // ****************************************
   // Palette and pixel encoding
   // ****************************************
   localparam logic [1:0] COMP_RED   = 2'h0;
   localparam logic [1:0] COMP_BLUE  = 2'h2;
   localparam logic [7:0] BANK_B     = 8'h10;
   localparam logic [3:0] OPC_LOAD4  = 4'h7;
   localparam logic [7:0] OPC_LOAD8  = 8'hbf;
   localparam logic [2:0] MIX8_TOP   = 3'h6;
   localparam logic [4:0] MIX_FULL   = 5'h1f;
   localparam logic [12:0] MIX_ROUND = 13'h0010;

   typedef enum logic [1:0] {ENC_BASIC8, ENC_ADV4, ENC_ADV8, ENC_SPARE} pbm_enc_e;
   typedef enum logic [2:0] {LD_IDLE, LD_ADDR, LD_RED, LD_GREEN, LD_BLUE} pbm_load_e;

   function automatic logic [4:0] mix_weight(input logic [2:0] m);
      logic [4:0] w;
      w = 5'h00;
      case (m)
         3'h0: w = 5'h00;
         3'h1: w = 5'h04;
         3'h2: w = 5'h09;
         3'h3: w = 5'h0d;
         3'h4: w = 5'h12;
         3'h5: w = 5'h16;
         3'h6: w = 5'h1b;
         default: w = 5'h1f;
      endcase
      return w;
   endfunction

   // A gentle brightening curve; ends stay fixed at zero and full scale.
   function automatic logic [7:0] gamma(input logic [7:0] x);
      logic [15:0] p;
      p = {8'h00, x} * {8'h00, 8'hff - x};
      return x + p[15:9];
   endfunction

endpackage

// ===== pbm_mix_channel.sv
`timescale 1ns/1ps
module pbm_mix_channel (
   // Edge colours
   input  wire logic [7:0] col_a,
   input  wire logic [7:0] col_b,
   // Weight of the second colour
   input  wire logic [4:0] mix,
   // Result
   output logic      [7:0] mixed
);

   wire logic [12:0] sum;
   wire logic [12:0] quot;

   assign sum   = {5'h00, col_b} * {8'h00, mix} +
                  {5'h00, col_a} * {8'h00, pbm_pkg::MIX_FULL - mix} +
                  pbm_pkg::MIX_ROUND; // RULE_10
   assign quot  = sum / {8'h00, pbm_pkg::MIX_FULL}; // RULE_20
   assign mixed = quot[7:0]; // RULE_20

endmodule

// ===== pbm_palette_blend.sv
`timescale 1ns/1ps
module pbm_palette_blend (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // Pixel stream
   input  wire logic [7:0]  pix_data,
   input  wire logic        pix_active,
   // Colour outputs
   output logic      [7:0]  red_out,
   output logic      [7:0]  green_out,
   output logic      [7:0]  blue_out
);

   // ****************************************
   // Storage and state
   // ****************************************
   logic [7:0]  pal_red   [0:255];
   logic [7:0]  pal_green [0:255];
   logic [7:0]  pal_blue  [0:255];
   logic        wr_pend_r;
   logic        rd_pend_r;
   logic [7:0]  dp_addr_r;
   logic [31:0] hrdata_r;
   logic [7:0]  w_idx_r;
   logic [1:0]  w_comp_r;
   logic [7:0]  r_idx_r;
   logic [1:0]  r_comp_r;
   logic        wide8_r;
   logic [1:0]  key_r;
   logic        blend_r;
   logic [1:0]  enc_r;
   logic        dyn_r;
   logic        repl_r;
   logic        phase_r;
   pbm_pkg::pbm_load_e ld_r;
   pbm_pkg::pbm_load_e ld_nxt;
   logic [7:0]  ld_addr_r;
   logic [7:0]  ld_red_r;
   logic [7:0]  ld_green_r;
   logic [23:0] col_a_r;
   logic [23:0] col_b_r;
   logic [7:0]  red_r;
   logic [7:0]  green_r;
   logic [7:0]  blue_r;

   // ****************************************
   // Bus decode
   // ****************************************
   wire logic       acc     = hsel & htrans[1] & hready;
   wire logic       mapped  = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
   wire logic [7:0] acc_adr = mapped ? haddr[7:0] : pbm_pkg::A_NONE;
   wire logic       we_waddr = wr_pend_r & (dp_addr_r == pbm_pkg::A_WADDR);
   wire logic       we_data  = wr_pend_r & (dp_addr_r == pbm_pkg::A_DATA);
   wire logic       we_raddr = wr_pend_r & (dp_addr_r == pbm_pkg::A_RADDR);
   wire logic       we_ctrl  = wr_pend_r & (dp_addr_r == pbm_pkg::A_CTRL);
   wire logic       re_data  = rd_pend_r & (dp_addr_r == pbm_pkg::A_DATA);
   wire logic [7:0] wdat     = hwdata[7:0];

   // Full-width storage once blending is on or the wide width is chosen.
   wire logic       raw      = blend_r | wide8_r; // RULE_03 RULE_07
   wire logic [7:0] wr_byte  = raw ? wdat : {wdat[5:0], 2'h0}; // RULE_04 RULE_06
   wire logic       w_last   = (w_comp_r == pbm_pkg::COMP_BLUE);
   wire logic       r_last   = (r_comp_r == pbm_pkg::COMP_BLUE);
   wire logic       mode_hit = we_data & w_last & (w_idx_r == pbm_pkg::MODE_ENTRY);
   wire logic       mode_ld  = mode_hit & (key_r == pbm_pkg::KEY_DONE); // RULE_02
   wire logic       mode_rd  = r_last & (r_idx_r == pbm_pkg::MODE_ENTRY);
   wire logic [7:0] rd_byte  = (r_comp_r == pbm_pkg::COMP_RED) ? pal_red[r_idx_r] :
                               r_last ? pal_blue[r_idx_r] : pal_green[r_idx_r];
   wire logic [7:0] rd_ret   = (raw | mode_rd) ? rd_byte : {2'h0, rd_byte[7:2]}; // RULE_05 RULE_06
   wire logic [7:0] status   = {3'h0, repl_r, dyn_r, enc_r, blend_r};
   wire logic [7:0] rd_val   = (dp_addr_r == pbm_pkg::A_DATA)   ? rd_ret :
                               (dp_addr_r == pbm_pkg::A_WADDR)  ? w_idx_r :
                               (dp_addr_r == pbm_pkg::A_RADDR)  ? r_idx_r :
                               (dp_addr_r == pbm_pkg::A_CTRL)   ? {7'h00, wide8_r} :
                               (dp_addr_r == pbm_pkg::A_STATUS) ? status : 8'h00;
   wire logic [7:0] key_val  = (key_r == 2'h0) ? pbm_pkg::KEY0 :
                               (key_r == 2'h1) ? pbm_pkg::KEY1 : pbm_pkg::KEY2;
   wire logic       key_step = we_waddr & (wdat == key_val) & (key_r != pbm_pkg::KEY_DONE);

   assign hreadyout = ~rd_pend_r;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   // Reads take one wait state so that a write just before them has landed.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         dp_addr_r <= pbm_pkg::A_NONE;
         hrdata_r  <= 32'h00000000;
      end else begin
         wr_pend_r <= acc & hwrite;
         rd_pend_r <= acc & ~hwrite;
         if (acc) begin
            dp_addr_r <= acc_adr;
         end
         if (rd_pend_r) begin
            hrdata_r <= {24'h000000, rd_val};
         end
      end
   end

   // ****************************************
   // Palette port and mode state
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         w_idx_r  <= 8'h00;
         w_comp_r <= pbm_pkg::COMP_RED;
         r_idx_r  <= 8'h00;
         r_comp_r <= pbm_pkg::COMP_RED;
         wide8_r  <= pbm_pkg::WIDE8_RESET;
         key_r    <= 2'h0;
      end else begin
         if (we_waddr) begin
            w_idx_r  <= wdat;
            w_comp_r <= pbm_pkg::COMP_RED;
         end else if (we_data) begin
            w_comp_r <= w_last ? pbm_pkg::COMP_RED : w_comp_r + 2'h1;
            w_idx_r  <= w_last ? w_idx_r + 8'h01 : w_idx_r;
         end
         if (we_raddr) begin
            r_idx_r  <= wdat;
            r_comp_r <= pbm_pkg::COMP_RED;
         end else if (re_data) begin
            r_comp_r <= r_last ? pbm_pkg::COMP_RED : r_comp_r + 2'h1;
            r_idx_r  <= r_last ? r_idx_r + 8'h01 : r_idx_r;
         end
         if (we_ctrl) begin
            wide8_r <= wdat[pbm_pkg::CTRL_WIDE8]; // RULE_03
         end
         if (key_step) begin
            key_r <= key_r + 2'h1; // RULE_02
         end else if (we_waddr) begin
            key_r <= (wdat == pbm_pkg::KEY0) ? 2'h1 : 2'h0;
         end else if (we_raddr | we_ctrl | mode_ld) begin
            key_r <= 2'h0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blend_r <= 1'b0; // RULE_01
         enc_r   <= 2'h0;
         dyn_r   <= 1'b0;
         repl_r  <= 1'b0;
      end else if (mode_ld) begin
         blend_r <= wr_byte[pbm_pkg::MODE_BLEND]; // RULE_19
         enc_r   <= wr_byte[pbm_pkg::MODE_ENC +: 2];
         dyn_r   <= wr_byte[pbm_pkg::MODE_DYN];
         repl_r  <= wr_byte[pbm_pkg::MODE_REPL];
      end
   end

   // ****************************************
   // Pixel decode
   // ****************************************
   // A replicated pixel is skipped so that opcode and data pairs stay aligned.
   wire logic       take    = pix_active & (~(blend_r & repl_r) | ~phase_r); // RULE_14
   wire logic       basic   = (enc_r == pbm_pkg::ENC_BASIC8);
   wire logic       adv4    = (enc_r == pbm_pkg::ENC_ADV4);
   wire logic       dyn_ok  = dyn_r & ~basic; // RULE_12
   wire logic [3:0] nib     = pix_data[3:0];
   wire logic       is_ld   = dyn_ok & (adv4 ? (nib == pbm_pkg::OPC_LOAD4) :
                                                (pix_data == pbm_pkg::OPC_LOAD8)); // RULE_18
   wire logic       adv_mix = adv4 ? nib[3] : (pix_data[7:5] == pbm_pkg::MIX8_TOP);
   wire logic [4:0] adv_w   = adv4 ? pbm_pkg::mix_weight(nib[2:0]) : pix_data[4:0];
   wire logic [4:0] mix_w   = basic ? pbm_pkg::mix_weight(pix_data[7:5]) : adv_w; // RULE_17
   wire logic [7:0] sel_idx = ~blend_r ? pix_data :
                              basic ? (pix_data[4] ? {4'h0, nib} + pbm_pkg::BANK_B : {4'h0, nib}) :
                              adv4 ? {4'h0, nib} : pix_data; // RULE_16
   wire logic [23:0] lut    = {pal_red[sel_idx], pal_green[sel_idx], pal_blue[sel_idx]};
   wire logic       in_ld   = (ld_r != pbm_pkg::LD_IDLE);
   wire logic       adv_col = ~basic & ~adv_mix & ~is_ld & ~in_ld;
   wire logic [7:0] ld_byte = adv4 ? {nib, nib} : pix_data;
   wire logic [23:0] a_nxt  = (basic & ~pix_data[4]) | adv_col ? lut : col_a_r; // RULE_09
   wire logic [23:0] b_nxt  = (basic & pix_data[4]) ? lut : adv_col ? col_a_r : col_b_r; // RULE_09
   wire logic       show_mx = basic | (adv_mix & ~is_ld & ~in_ld);
   wire logic [23:0] mixed;
   wire logic [23:0] blend_c = show_mx ? mixed : a_nxt;
   wire logic [23:0] pix_c   = blend_r ? {pbm_pkg::gamma(blend_c[23:16]), pbm_pkg::gamma(blend_c[15:8]),
                                          pbm_pkg::gamma(blend_c[7:0])} : lut; // RULE_15 RULE_01
   wire logic       ld_we   = take & blend_r & (ld_r == pbm_pkg::LD_BLUE);

   // Three identical channels run side by side on every pixel.
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++) begin : g_chan
         pbm_mix_channel u_mix ( // RULE_11
            .col_a (a_nxt[ch*8 +: 8]),
            .col_b (b_nxt[ch*8 +: 8]),
            .mix   (mix_w),
            .mixed (mixed[ch*8 +: 8])
         );
      end
   endgenerate

   always_comb begin
      ld_nxt = ld_r;
      case (ld_r)
         pbm_pkg::LD_IDLE:  ld_nxt = is_ld ? pbm_pkg::LD_ADDR : pbm_pkg::LD_IDLE; // RULE_13
         pbm_pkg::LD_ADDR:  ld_nxt = pbm_pkg::LD_RED;
         pbm_pkg::LD_RED:   ld_nxt = pbm_pkg::LD_GREEN;
         pbm_pkg::LD_GREEN: ld_nxt = pbm_pkg::LD_BLUE;
         pbm_pkg::LD_BLUE:  ld_nxt = pbm_pkg::LD_IDLE;
         default:           ld_nxt = pbm_pkg::LD_IDLE;
      endcase
   end

   // ****************************************
   // Pixel state and outputs
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_r    <= 1'b0;
         ld_r       <= pbm_pkg::LD_IDLE;
         ld_addr_r  <= 8'h00;
         ld_red_r   <= 8'h00;
         ld_green_r <= 8'h00;
         col_a_r    <= 24'h000000;
         col_b_r    <= 24'h000000;
         red_r      <= 8'h00;
         green_r    <= 8'h00;
         blue_r     <= 8'h00;
      end else begin
         phase_r <= pix_active & ~phase_r;
         if (!blend_r) begin
            ld_r <= pbm_pkg::LD_IDLE;
         end else if (take) begin
            ld_r <= ld_nxt;
            col_a_r <= a_nxt;
            col_b_r <= b_nxt;
            case (ld_r)
               pbm_pkg::LD_ADDR:  ld_addr_r  <= adv4 ? {4'h0, nib} : pix_data;
               pbm_pkg::LD_RED:   ld_red_r   <= ld_byte;
               pbm_pkg::LD_GREEN: ld_green_r <= ld_byte;
               default:           ld_addr_r  <= ld_addr_r;
            endcase
         end
         if (!pix_active) begin
            red_r   <= 8'h00;
            green_r <= 8'h00;
            blue_r  <= 8'h00;
         end else if (take) begin
            red_r   <= pix_c[23:16];
            green_r <= pix_c[15:8];
            blue_r  <= pix_c[7:0];
         end
      end
   end

   assign red_out   = red_r;
   assign green_out = green_r;
   assign blue_out  = blue_r;

   // The host write lands last, so it wins a same-entry clash with a bitmap load.
   always_ff @(posedge hclk) begin
      if (ld_we) begin
         pal_red[ld_addr_r]   <= ld_red_r; // RULE_13
         pal_green[ld_addr_r] <= ld_green_r;
         pal_blue[ld_addr_r]  <= ld_byte;
      end
      if (we_data) begin
         case (w_comp_r)
            pbm_pkg::COMP_RED:  pal_red[w_idx_r]  <= wr_byte;
            pbm_pkg::COMP_BLUE: pal_blue[w_idx_r] <= wr_byte;
            default:            pal_green[w_idx_r] <= wr_byte;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_reset_compat;
      @(posedge hclk) disable iff (!hresetn) $rose(blend_r) |-> $past(mode_hit) && $past(key_r) == 2'h3;
   endproperty
   a_reset_compat: assert property (p_reset_compat) else $error("blend enabled without key"); // RULE_02

   property p_compat_bypass;
      @(posedge hclk) disable iff (!hresetn)
         !blend_r && pix_active && !mode_ld ##0 $stable(blend_r) |=> red_out == $past(pal_red[pix_data]);
   endproperty
   a_compat_bypass: assert property (p_compat_bypass) else $error("compat red not palette"); // RULE_01

   property p_no_gamma;
      @(posedge hclk) disable iff (!hresetn)
         !blend_r && !$past(blend_r) && pix_active |=> blue_out == $past(pal_blue[pix_data]);
   endproperty
   a_no_gamma: assert property (p_no_gamma) else $error("gamma seen in compat"); // RULE_15

   property p_narrow_write;
      @(posedge hclk) disable iff (!hresetn)
         we_data && !blend_r && !wide8_r && w_comp_r == pbm_pkg::COMP_RED |=>
            pal_red[$past(w_idx_r)] == {$past(hwdata[5:0]), 2'h0};
   endproperty
   a_narrow_write: assert property (p_narrow_write) else $error("narrow write not shifted"); // RULE_04

   property p_narrow_read;
      @(posedge hclk) disable iff (!hresetn)
         re_data && !blend_r && !wide8_r && !mode_rd |=> hrdata[7:6] == 2'h0 && hreadyout;
   endproperty
   a_narrow_read: assert property (p_narrow_read) else $error("narrow read upper bits set"); // RULE_05

   property p_raw_write;
      @(posedge hclk) disable iff (!hresetn)
         we_data && blend_r && w_comp_r == pbm_pkg::COMP_RED |=> pal_red[$past(w_idx_r)] == $past(hwdata[7:0]);
   endproperty
   a_raw_write: assert property (p_raw_write) else $error("blend write shifted"); // RULE_07

   property p_edge_regs;
      @(posedge hclk) disable iff (!hresetn) blend_r && take && adv_col |=> col_b_r == $past(col_a_r);
   endproperty
   a_edge_regs: assert property (p_edge_regs) else $error("left colour not moved"); // RULE_09

   property p_repl;
      @(posedge hclk) disable iff (!hresetn) blend_r && repl_r && take ##1 pix_active |-> !take;
   endproperty
   a_repl: assert property (p_repl) else $error("replicated pixel taken"); // RULE_14

   property p_load_seq;
      @(posedge hclk) disable iff (!hresetn)
         blend_r && take && is_ld && ld_r == pbm_pkg::LD_IDLE |=> ld_r == pbm_pkg::LD_ADDR;
   endproperty
   a_load_seq: assert property (p_load_seq) else $error("load opcode ignored"); // RULE_13

   property p_read_wait;
      @(posedge hclk) disable iff (!hresetn) acc && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

   c_mode_load: cover property (@(posedge hclk) disable iff (!hresetn) mode_ld);
   c_bitmap_load: cover property (@(posedge hclk) disable iff (!hresetn) ld_we);
   c_mix_pixel: cover property (@(posedge hclk) disable iff (!hresetn) blend_r && take && show_mx);
   c_read: cover property (@(posedge hclk) disable iff (!hresetn) re_data);

endmodule

// ===== pbm_pix_source.sv
`timescale 1ns/1ps
module pbm_pix_source (
   // Clock
   input  wire logic       hclk,
   // Pixel stream
   output logic      [7:0] pix_data,
   output logic            pix_active
);
   // ****************************************
   // Stream tasks
   // ****************************************
   initial begin
      pix_data   = 8'h00;
      pix_active = 1'b0;
   end
   // One pixel per clock, held for n clocks.
   task automatic send(input logic [7:0] p, input int n);
      repeat (n) begin
         pix_data   <= p;
         pix_active <= 1'b1;
         @(posedge hclk);
      end
   endtask
   // Blanking data is meaningless, so it toggles to expose any reliance on it.
   task automatic blank(input int n);
      repeat (n) begin
         pix_data   <= ~pix_data;
         pix_active <= 1'b0;
         @(posedge hclk);
      end
   endtask
endmodule

// ===== test_pbm_palette_blend.sv
`timescale 1ns/1ps
module test_pbm_palette_blend;
   // ****************************************
   // Signals
   // ****************************************
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [7:0]  pix_data;
   logic        pix_active;
   logic [7:0]  red_out;
   logic [7:0]  green_out;
   logic [7:0]  blue_out;
   int          miscompares;
   int          comparisons;
   localparam logic [4:0] WT [8] = '{5'h00, 5'h04, 5'h09, 5'h0d, 5'h12, 5'h16, 5'h1b, 5'h1f};
   assign hready = hreadyout;
   pbm_palette_blend pbm_palette_blend_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pix_data(pix_data),
      .pix_active(pix_active), .red_out(red_out), .green_out(green_out), .blue_out(blue_out));
   pbm_pix_source pbm_pix_source_inst (.hclk(hclk), .pix_data(pix_data), .pix_active(pix_active));
   always #5 hclk = ~hclk;
   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // The master never assumes a latency; a stuck slave is cut off by the watchdog.
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [31:0] x;
      ahb(a, 1'b1, {24'h000000, v}, x);
   endtask
   task automatic pal_write(input logic [7:0] i, input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
      wr(pbm_pkg::A_WADDR, i);
      wr(pbm_pkg::A_DATA, r);
      wr(pbm_pkg::A_DATA, g);
      wr(pbm_pkg::A_DATA, b);
   endtask
   task automatic pal_check(input logic [7:0] i, input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
      logic [31:0] x;
      wr(pbm_pkg::A_RADDR, i);
      ahb(pbm_pkg::A_DATA, 1'b0, 32'h0, x);
      check("red", x, {24'h0, r});
      ahb(pbm_pkg::A_DATA, 1'b0, 32'h0, x);
      check("green", x, {24'h0, g});
      ahb(pbm_pkg::A_DATA, 1'b0, 32'h0, x);
      check("blue", x, {24'h0, b});
   endtask
   task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      ahb(a, 1'b0, 32'h0, x);
      check("register", x, exp);
   endtask
   task automatic unlock(input logic [7:0] mode);
      wr(pbm_pkg::A_WADDR, pbm_pkg::KEY0);
      wr(pbm_pkg::A_WADDR, pbm_pkg::KEY1);
      wr(pbm_pkg::A_WADDR, pbm_pkg::KEY2);
      wr(pbm_pkg::A_DATA, 8'h00);
      wr(pbm_pkg::A_DATA, 8'h00);
      wr(pbm_pkg::A_DATA, mode);
   endtask
   task automatic see_rgb(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
      @(negedge hclk);
      check("red_out", {24'h0, red_out}, {24'h0, r});
      check("green_out", {24'h0, green_out}, {24'h0, g});
      check("blue_out", {24'h0, blue_out}, {24'h0, b});
      @(posedge hclk);
   endtask
   function automatic logic [7:0] blend_exp(input int a, input int b, input int w);
      int m;
      m = (b * w + a * (31 - w) + 16) / 31;
      return 8'(m + ((m * (255 - m)) >> 9));
   endfunction
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_compat;
      reg_check(pbm_pkg::A_STATUS, 32'h0);
      reg_check(pbm_pkg::A_CTRL, 32'h0);
      reg_check(8'h20, 32'h0);
      pal_write(8'h02, 8'h3f, 8'h15, 8'h2a);
      pal_check(8'h02, 8'h3f, 8'h15, 8'h2a);
      pbm_pix_source_inst.send(8'h02, 2);
      see_rgb(8'hfc, 8'h54, 8'ha8);
      pbm_pix_source_inst.blank(2);
      see_rgb(8'h00, 8'h00, 8'h00);
      pal_write(8'hdf, 8'h01, 8'h02, 8'h15);
      pal_check(8'hdf, 8'h01, 8'h02, 8'h54);
      reg_check(pbm_pkg::A_STATUS, 32'h0);
   endtask
   task automatic t_wide;
      wr(pbm_pkg::A_CTRL, 8'h01);
      pal_write(8'h04, 8'hc5, 8'h3a, 8'h81);
      pal_check(8'h04, 8'hc5, 8'h3a, 8'h81);
      wr(pbm_pkg::A_CTRL, 8'h00);
   endtask
   task automatic t_basic;
      unlock(8'h01);
      reg_check(pbm_pkg::A_STATUS, 32'h1);
      pal_write(8'h05, 8'h20, 8'h80, 8'hf0);
      pal_write(8'h15, 8'he0, 8'h10, 8'h04);
      pal_check(8'h05, 8'h20, 8'h80, 8'hf0);
      pbm_pix_source_inst.send(8'h05, 2);
      see_rgb(blend_exp(32, 224, 0), blend_exp(128, 16, 0), blend_exp(240, 4, 0));
      pbm_pix_source_inst.send(8'hf5, 2);
      see_rgb(blend_exp(32, 224, 31), blend_exp(128, 16, 31), blend_exp(240, 4, 31));
      for (int m = 0; m < 8; m++) begin
         pbm_pix_source_inst.send({3'(m), 5'h05}, 2);
         see_rgb(blend_exp(32, 224, WT[m]), blend_exp(128, 16, WT[m]), blend_exp(240, 4, WT[m]));
      end
      pbm_pix_source_inst.blank(2);
   endtask
   task automatic t_dynamic;
      unlock(8'h34);
      reg_check(pbm_pkg::A_STATUS, 32'hd);
      pbm_pix_source_inst.send(8'hbf, 1);
      pbm_pix_source_inst.send(8'h40, 1);
      pbm_pix_source_inst.send(8'h12, 1);
      pbm_pix_source_inst.send(8'h34, 1);
      pbm_pix_source_inst.send(8'h56, 1);
      pbm_pix_source_inst.blank(2);
      pal_check(8'h40, 8'h12, 8'h34, 8'h56);
      pbm_pix_source_inst.send(8'h40, 1);
      pbm_pix_source_inst.send(8'h05, 1);
      pbm_pix_source_inst.send(8'hca, 1);
      see_rgb(blend_exp(32, 18, 10), blend_exp(128, 52, 10), blend_exp(240, 86, 10));
      pbm_pix_source_inst.blank(2);
   endtask
   // Every pixel is sent twice, as a doubling display controller would.
   task automatic t_adv4;
      unlock(8'h6c);
      reg_check(pbm_pkg::A_STATUS, 32'h1b);
      pbm_pix_source_inst.send(8'h07, 2);
      pbm_pix_source_inst.send(8'h03, 2);
      pbm_pix_source_inst.send(8'h0a, 2);
      pbm_pix_source_inst.send(8'h05, 2);
      pbm_pix_source_inst.send(8'h0c, 2);
      pbm_pix_source_inst.send(8'h03, 2);
      pbm_pix_source_inst.send(8'h05, 2);
      pbm_pix_source_inst.send(8'hfc, 2);
      see_rgb(blend_exp(32, 170, 18), blend_exp(128, 85, 18), blend_exp(240, 204, 18));
      pbm_pix_source_inst.blank(2);
      pal_check(8'h03, 8'haa, 8'h55, 8'hcc);
   endtask
   task automatic t_rereset;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      reg_check(pbm_pkg::A_STATUS, 32'h0);
      pbm_pix_source_inst.send(8'h05, 2);
      see_rgb(8'h20, 8'h80, 8'hf0);
      pbm_pix_source_inst.blank(1);
   endtask
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      miscompares = 0;
      comparisons = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_compat;
      t_wide;
      t_basic;
      t_dynamic;
      t_adv4;
      t_rereset;
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      miscompares++;
      tally_and_finish;
   end
endmodule
